// >>> design/vfe_fmt_chan.sv
// per-channel data format classifier, commits once per frame
`timescale 1ns/1ns
module vfe_fmt_chan
    import vfe_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       en,
    input  wire logic       frame_end,
    input  wire logic       trs_seen,
    input  wire logic       sdti_hdr,
    input  wire logic [3:0] sdti_code,
    input  wire logic       tdm_hdr,
    input  wire logic       hd_sdti,
    output logic      [3:0] fmt_code_r
);
    vfe_fc_state_t state_r, state_nxt;
    logic [3:0]    fmt_nxt, code_r, code_nxt;
    logic          trs_r, sdti_r, tdm_r, hds_r;
    logic          trs_nxt, sdti_nxt, tdm_nxt, hds_nxt;
    logic          t, s, d, h;

    // =========================================================
    // classification
    // flags gathered over a frame; a header seen in the commit
    // cycle still counts, so nothing is lost at the boundary
    always_comb begin
        t = trs_r | trs_seen;
        s = sdti_r | sdti_hdr;
        d = tdm_r | tdm_hdr;
        h = hds_r | hd_sdti;
        state_nxt = state_r;
        fmt_nxt   = fmt_code_r;
        code_nxt  = sdti_hdr ? sdti_code : code_r;
        trs_nxt   = frame_end ? trs_seen : t;
        sdti_nxt  = frame_end ? sdti_hdr : s;
        tdm_nxt   = frame_end ? tdm_hdr : d;
        hds_nxt   = frame_end ? hd_sdti : h;
        case (state_r)
            FC_IDLE: begin
                fmt_nxt   = FMT_UNDEF;
                state_nxt = FC_SCAN;
            end
            FC_SCAN: begin
                if (frame_end) begin
                    if (!t)
                        fmt_nxt = FMT_UNDEF;
                    else if (d)
                        fmt_nxt = FMT_TDM;
                    else if (s && h)
                        fmt_nxt = FMT_HDSDTI;
                    else if (s)
                        fmt_nxt = (code_nxt > FMT_SDTI_MAX) ?
                                  FMT_SDTI_MAX : code_nxt;
                    else
                        fmt_nxt = FMT_SDI;
                end
            end
            default: state_nxt = FC_IDLE;
        endcase
        // classification only runs while enabled
        if (!en) begin
            state_nxt = FC_IDLE;
            fmt_nxt   = FMT_UNDEF;
            trs_nxt   = 1'b0;
            sdti_nxt  = 1'b0;
            tdm_nxt   = 1'b0;
            hds_nxt   = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r    <= FC_IDLE;
            fmt_code_r <= FMT_UNDEF;
            code_r     <= 4'h0;
            trs_r      <= 1'b0;
            sdti_r     <= 1'b0;
            tdm_r      <= 1'b0;
            hds_r      <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            fmt_code_r <= fmt_nxt;
            code_r     <= code_nxt;
            trs_r      <= trs_nxt;
            sdti_r     <= sdti_nxt;
            tdm_r      <= tdm_nxt;
            hds_r      <= hds_nxt;
        end
    end

    // =========================================================
    // checks
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_disabled_undef: assert property (
        !en |=> fmt_code_r == FMT_UNDEF)
        else $error("format not undefined while disabled");
    a_sdi_class: assert property (
        en && state_r == FC_SCAN && frame_end && t && !s && !d
        |=> fmt_code_r == FMT_SDI)
        else $error("trs without headers not sdi");
    a_tdm_class: assert property (
        en && state_r == FC_SCAN && frame_end && t && d
        |=> fmt_code_r == FMT_TDM)
        else $error("tdm header not reported");
    a_no_trs_undef: assert property (
        en && state_r == FC_SCAN && frame_end && !t
        |=> fmt_code_r == FMT_UNDEF)
        else $error("no trs but format known");
    a_sdti_range: assert property (
        en && state_r == FC_SCAN && frame_end && t && s && !d && !h
        |=> fmt_code_r <= FMT_SDTI_MAX)
        else $error("sdti code out of range");

endmodule // vfe_fmt_chan

// >>> design/vfe_pkg.sv
// shared constants for the video format, edh and standard status block
package vfe_pkg;

    // register map, word offsets on the plain register port
    localparam logic [3:0] ADDR_STD  = 4'h0;
    localparam logic [3:0] ADDR_FMT  = 4'h1;
    localparam logic [3:0] ADDR_EDH  = 4'h2;
    localparam logic [3:0] ADDR_CTRL = 4'h3;

    // control register fields and reset values
    localparam int         CTRL_TOL_LSB = 0;
    localparam int         CTRL_MF_LSB  = 4;
    localparam logic [3:0] TOL_RESET    = 4'h0;
    localparam logic [3:0] TOL_MAX      = 4'h4;
    localparam logic [1:0] MF_RESET     = 2'h0;
    localparam logic [1:0] MF_EDH       = 2'h0;
    localparam logic [1:0] MF_STDLOCK   = 2'h1;
    localparam logic [1:0] MF_LOCKED    = 2'h2;

    // data format codes
    localparam logic [3:0] FMT_SDTI_MAX = 4'h5;
    localparam logic [3:0] FMT_SDI      = 4'h6;
    localparam logic [3:0] FMT_TDM      = 4'h8;
    localparam logic [3:0] FMT_HDSDTI   = 4'h9;
    localparam logic [3:0] FMT_UNDEF    = 4'hF;

    // rate indication and standard codes for unknown rasters
    localparam logic [1:0] RATE_HD      = 2'h0;
    localparam logic [1:0] RATE_3G      = 2'h2;
    localparam logic [5:0] STD_NONE     = 6'h00;
    localparam logic [5:0] STD_UNK_HD   = 6'h1D;
    localparam logic [5:0] STD_UNK_SD   = 6'h1E;
    localparam logic [5:0] STD_UNK_3G   = 6'h3C;
    localparam logic [5:0] STD_625I     = 6'h18;

    // raster table: lines/frame, words/line, active words, code
    localparam int N_STD = 12;
    localparam logic [10:0] LPF_525 = 11'h20D;
    localparam logic [10:0] LPF_625 = 11'h271;
    localparam logic [10:0] LPF_750 = 11'h2EE;
    localparam logic [10:0] TAB_LPF [N_STD] = '{
        LPF_750, LPF_750, LPF_750, LPF_750, LPF_750, LPF_750,
        LPF_750, LPF_750, LPF_525, LPF_625, LPF_525, LPF_625};
    localparam logic [13:0] TAB_WPL [N_STD] = '{
        14'h07BC, 14'h07BC, 14'h0F78, 14'h0F78, 14'h101D, 14'h101D,
        14'h0672, 14'h0672, 14'h06B4, 14'h06C0, 14'h06B4, 14'h06C0};
    // zero active width marks a generic entry that accepts any width
    localparam logic [13:0] TAB_AWPL [N_STD] = '{
        14'h0500, 14'h06C0, 14'h0500, 14'h0D80, 14'h0500, 14'h0E10,
        14'h0500, 14'h05A0, 14'h05A0, 14'h05A0, 14'h0000, 14'h0000};
    localparam logic [5:0] TAB_CODE [N_STD] = '{
        6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09,
        6'h00, 6'h01, 6'h16, STD_625I, 6'h19, 6'h1A};
    localparam logic [N_STD-1:0] TAB_SD = 12'hF00;

    // raster layout field values
    localparam logic [1:0] RAS_525 = 2'h1;
    localparam logic [1:0] RAS_625 = 2'h2;
    localparam logic [1:0] RAS_750 = 2'h3;

    // per-channel classifier states, gray along idle -> scan
    typedef enum logic [1:0] {
        FC_IDLE = 2'b00,
        FC_SCAN = 2'b01
    } vfe_fc_state_t;

endpackage

// >>> design/vfe_status_top.sv
// video standard, data format and edh presence status block
//
// Summary of operation
// - detected standard is reported as a numeric code in a status field
// - 625-line interlaced, 1440 of 1728 words, SD rate reports 18h
// - after reset raster, code, lock and interlace fields read zero
// - bypass pin low forces raster, code, lock and interlace to zero
// - data format classified only while receiver lock is high
// - format fields read Fh at reset, without lock or in bypass
// - format codes: 0-5 SDTI, 6 SDI, 8 TDM, 9 HD-SDTI, F other
// - trs present without sdti or tdm header means SDI
// - trs present with sdti header but no tdm or hd-sdti header means SDTI
// - trs present with tdm header means TDM
// - lock held but no trs found means unknown format
// - luma and chroma keep independent format fields at HD rates
// - at SD only luma reports; chroma field holds Fh
// - edh presence rises on an edh packet and stays while they come
// - at vertical falling edge, no edh in blanking clears presence
// - edh presence selectable on the mf pin and readable by host
`timescale 1ns/1ns
module vfe_status_top
    import vfe_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST_N,
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output logic      [15:0] REG_RDATA,
    input  wire logic        PROCESSING_BYPASS_N,
    input  wire logic        LOCKED,
    input  wire logic [1:0]  RATE_INDICATION,
    input  wire logic        MEAS_VALID,
    input  wire logic [10:0] MEAS_LINES,
    input  wire logic [13:0] MEAS_WORDS,
    input  wire logic [13:0] MEAS_ACTIVE,
    input  wire logic        MEAS_INTERLACED,
    input  wire logic        VBLANK,
    input  wire logic        EDH_PKT,
    input  wire logic        Y_TRS,
    input  wire logic        Y_SDTI,
    input  wire logic [3:0]  Y_SDTI_CODE,
    input  wire logic        Y_TDM,
    input  wire logic        Y_HDSDTI,
    input  wire logic        C_TRS,
    input  wire logic        C_SDTI,
    input  wire logic [3:0]  C_SDTI_CODE,
    input  wire logic        C_TDM,
    input  wire logic        C_HDSDTI,
    output logic             EDH_PRESENT_FLAG,
    output logic             MF_OUT
);
    // =========================================================
    // declarations
    logic [1:0]  byp_sync_r, lock_sync_r;
    logic        bypass_n_s, locked_s;
    logic [5:0]  standard_code_r, standard_code_nxt;
    logic [1:0]  rate_indication_r, rate_nxt;
    logic        standard_locked_flag_r, standard_locked_flag_nxt;
    logic        interlace_progressive_flag_r, ilace_nxt;
    logic [1:0]  raster_layout_field_r, raster_nxt;
    logic [5:0]  cand_code;
    logic        cand_hit;
    logic [1:0]  cand_ras;
    logic [13:0] wdist;
    logic        rate_ok;
    logic [3:0]  ctrl_tol_r, ctrl_tol_nxt;
    logic [1:0]  mf_sel_r, mf_sel_nxt;
    logic [15:0] rdata_nxt;
    logic        v_d_r;
    logic        v_fall;
    logic        edh_seen_r, edh_seen_nxt;
    logic        edh_present_flag_r, edh_nxt;
    logic        mf_nxt;
    logic [1:0]  fmt_en;
    logic [1:0]  ch_trs, ch_sdti, ch_tdm, ch_hds;
    logic [3:0]  ch_code [2];
    logic [3:0]  ch_fmt [2];
    logic [7:0]  format_status_field;

    // =========================================================
    // pin synchronisers
    // both pins come from outside the core clock; only the
    // second stage is read anywhere
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            byp_sync_r  <= 2'b00;
            lock_sync_r <= 2'b00;
        end else begin
            byp_sync_r  <= {byp_sync_r[0], PROCESSING_BYPASS_N};
            lock_sync_r <= {lock_sync_r[0], LOCKED};
        end
    end
    assign bypass_n_s = byp_sync_r[1];
    assign locked_s   = lock_sync_r[1];

    // =========================================================
    // standard detection
    // table search; lowest index wins so generic entries sit last
    always_comb begin
        cand_hit  = 1'b0;
        cand_code = STD_NONE;
        wdist     = 14'h0000;
        rate_ok   = 1'b0;
        for (int i = N_STD - 1; i >= 0; i--) begin
            wdist = (MEAS_WORDS >= TAB_WPL[i]) ?
                    MEAS_WORDS - TAB_WPL[i] : TAB_WPL[i] - MEAS_WORDS;
            rate_ok = TAB_SD[i] ? RATE_INDICATION[0] :
                      (RATE_INDICATION == RATE_HD);
            // word count matched within the host tolerance
            if (rate_ok && MEAS_LINES == TAB_LPF[i] &&
                wdist <= {10'h000, ctrl_tol_r} &&
                (TAB_AWPL[i] == 14'h0000 ||
                 (MEAS_ACTIVE == TAB_AWPL[i] &&
                  (!TAB_SD[i] || MEAS_INTERLACED)))) begin
                cand_hit  = 1'b1;
                cand_code = TAB_CODE[i];
            end
        end
        // rate known, raster not: one code per rate
        if (!cand_hit) begin
            if (RATE_INDICATION[0])
                cand_code = STD_UNK_SD;
            else if (RATE_INDICATION == RATE_3G)
                cand_code = STD_UNK_3G;
            else
                cand_code = STD_UNK_HD;
        end
        case (MEAS_LINES)
            LPF_525: cand_ras = RAS_525;
            LPF_625: cand_ras = RAS_625;
            LPF_750: cand_ras = RAS_750;
            default: cand_ras = 2'h0;
        endcase
    end

    // next values for the standard status fields
    // lock needs two equal known results in a row, which rides
    // out a single corrupted measurement at the cost of a frame
    always_comb begin
        standard_code_nxt = standard_code_r;
        rate_nxt          = rate_indication_r;
        standard_locked_flag_nxt      = standard_locked_flag_r;
        ilace_nxt         = interlace_progressive_flag_r;
        raster_nxt        = raster_layout_field_r;
        if (!bypass_n_s) begin
            standard_code_nxt = STD_NONE;
            standard_locked_flag_nxt      = 1'b0;
            ilace_nxt         = 1'b0;
            raster_nxt        = 2'h0;
            rate_nxt          = RATE_INDICATION;
        end else if (MEAS_VALID) begin
            standard_code_nxt = cand_code;
            rate_nxt          = RATE_INDICATION;
            standard_locked_flag_nxt      = cand_hit &&
                                cand_code == standard_code_r;
            ilace_nxt         = MEAS_INTERLACED;
            raster_nxt        = cand_ras;
        end else begin
            rate_nxt          = RATE_INDICATION;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            standard_code_r              <= STD_NONE;
            rate_indication_r            <= RATE_HD;
            standard_locked_flag_r       <= 1'b0;
            interlace_progressive_flag_r <= 1'b0;
            raster_layout_field_r        <= 2'h0;
        end else begin
            standard_code_r              <= standard_code_nxt;
            rate_indication_r            <= rate_nxt;
            standard_locked_flag_r       <= standard_locked_flag_nxt;
            interlace_progressive_flag_r <= ilace_nxt;
            raster_layout_field_r        <= raster_nxt;
        end
    end

    // =========================================================
    // data format, one classifier per channel
    assign ch_trs  = {C_TRS, Y_TRS};
    assign ch_sdti = {C_SDTI, Y_SDTI};
    assign ch_tdm  = {C_TDM, Y_TDM};
    assign ch_hds  = {C_HDSDTI, Y_HDSDTI};
    assign ch_code[0] = Y_SDTI_CODE;
    assign ch_code[1] = C_SDTI_CODE;
    // chroma runs only off SD; luma whenever locked, not bypassed
    assign fmt_en[0] = locked_s & bypass_n_s;
    assign fmt_en[1] = locked_s & bypass_n_s &
                       ~rate_indication_r[0];

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            vfe_fmt_chan u_chan (
                .clk        (CORE_CLK),
                .rst_n      (RST_N),
                .en         (fmt_en[ch]),
                .frame_end  (v_fall),
                .trs_seen   (ch_trs[ch]),
                .sdti_hdr   (ch_sdti[ch]),
                .sdti_code  (ch_code[ch]),
                .tdm_hdr    (ch_tdm[ch]),
                .hd_sdti    (ch_hds[ch]),
                .fmt_code_r (ch_fmt[ch])
            );
        end
    endgenerate
    assign format_status_field = {ch_fmt[1], ch_fmt[0]};

    // =========================================================
    // edh presence
    // a packet in the same cycle as the clearing edge wins
    assign v_fall = v_d_r & ~VBLANK;
    always_comb begin
        edh_seen_nxt = edh_seen_r;
        edh_nxt      = edh_present_flag_r;
        if (v_fall)
            edh_seen_nxt = 1'b0;
        if (VBLANK && EDH_PKT)
            edh_seen_nxt = 1'b1;
        if (v_fall && !edh_seen_r)
            edh_nxt = 1'b0;
        if (EDH_PKT)
            edh_nxt = 1'b1;
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            v_d_r              <= 1'b0;
            edh_seen_r         <= 1'b0;
            edh_present_flag_r <= 1'b0;
        end else begin
            v_d_r              <= VBLANK;
            edh_seen_r         <= edh_seen_nxt;
            edh_present_flag_r <= edh_nxt;
        end
    end

    // =========================================================
    // register port and multifunction pin
    // tolerance above the limit is clipped, not rejected
    always_comb begin
        ctrl_tol_nxt = ctrl_tol_r;
        mf_sel_nxt   = mf_sel_r;
        rdata_nxt    = 16'h0000;
        if (REG_WR && REG_ADDR == ADDR_CTRL) begin
            ctrl_tol_nxt = (REG_WDATA[CTRL_TOL_LSB +: 4] > TOL_MAX) ?
                           TOL_MAX : REG_WDATA[CTRL_TOL_LSB +: 4];
            mf_sel_nxt   = REG_WDATA[CTRL_MF_LSB +: 2];
        end
        if (REG_RD) begin
            case (REG_ADDR)
                ADDR_STD:  rdata_nxt = {4'h0, raster_layout_field_r,
                                        interlace_progressive_flag_r,
                                        standard_locked_flag_r,
                                        rate_indication_r,
                                        standard_code_r};
                ADDR_FMT:  rdata_nxt = {8'h00, format_status_field};
                ADDR_EDH:  rdata_nxt = {15'h0000,
                                        edh_present_flag_r};
                ADDR_CTRL: rdata_nxt = {10'h000, mf_sel_r, ctrl_tol_r};
                default:   rdata_nxt = 16'h0000;
            endcase
        end
        case (mf_sel_r)
            MF_EDH:     mf_nxt = edh_present_flag_r;
            MF_STDLOCK: mf_nxt = standard_locked_flag_r;
            MF_LOCKED:  mf_nxt = locked_s;
            default:    mf_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ctrl_tol_r <= TOL_RESET;
            mf_sel_r   <= MF_RESET;
            REG_RDATA  <= 16'h0000;
            MF_OUT     <= 1'b0;
        end else begin
            ctrl_tol_r <= ctrl_tol_nxt;
            mf_sel_r   <= mf_sel_nxt;
            REG_RDATA  <= rdata_nxt;
            MF_OUT     <= mf_nxt;
        end
    end
    assign EDH_PRESENT_FLAG = edh_present_flag_r;

    // =========================================================
    // checks
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    a_bypass_clears: assert property (!bypass_n_s |=>
        standard_code_r == STD_NONE && !standard_locked_flag_r &&
        !interlace_progressive_flag_r &&
        raster_layout_field_r == 2'h0)
        else $error("bypass did not clear standard fields");
    a_sd625_code: assert property (
        bypass_n_s && MEAS_VALID && RATE_INDICATION[0] &&
        MEAS_LINES == LPF_625 && MEAS_WORDS == TAB_WPL[9] &&
        MEAS_ACTIVE == TAB_AWPL[9] && MEAS_INTERLACED
        |=> standard_code_r == STD_625I && rate_indication_r[0])
        else $error("625 line sd not coded 18h");
    a_unknown_sd: assert property (
        bypass_n_s && MEAS_VALID && RATE_INDICATION[0] &&
        MEAS_LINES != LPF_525 && MEAS_LINES != LPF_625
        |=> standard_code_r == STD_UNK_SD)
        else $error("unknown sd raster not coded");
    a_chroma_sd: assert property (
        rate_indication_r[0] ##1 rate_indication_r[0]
        |-> ch_fmt[1] == FMT_UNDEF)
        else $error("chroma format not undefined in sd");
    a_unlock_undef: assert property (!locked_s |=>
        format_status_field == {FMT_UNDEF, FMT_UNDEF})
        else $error("format fields not undefined when unlocked");
    a_edh_sets: assert property (EDH_PKT |=>
        EDH_PRESENT_FLAG ##1 (EDH_PRESENT_FLAG || v_d_r))
        else $error("edh presence not raised");
    a_edh_clears: assert property (
        v_fall && !edh_seen_r && !EDH_PKT |=> !EDH_PRESENT_FLAG)
        else $error("edh presence not cleared after blanking");
    a_mf_edh: assert property (
        mf_sel_r == MF_EDH && $stable(mf_sel_r)
        |-> MF_OUT == $past(edh_present_flag_r))
        else $error("mf pin does not follow edh presence");
    a_tol_limit: assert property (ctrl_tol_r <= TOL_MAX)
        else $error("tolerance above limit");
    a_edh_readback: assert property (
        REG_RD && REG_ADDR == ADDR_EDH
        |=> REG_RDATA == {15'h0000, $past(edh_present_flag_r)})
        else $error("edh presence not readable by host");
    a_std_readback: assert property (
        REG_RD && REG_ADDR == ADDR_STD
        |=> REG_RDATA[5:0] == $past(standard_code_r))
        else $error("standard code not readable by host");
    // read data falls back to zero so a stale word never reads twice
    a_rdata_idle: assert property (!REG_RD |=> REG_RDATA == 16'h0000)
        else $error("read data not zero outside a read");
    a_mf_locked: assert property (
        mf_sel_r == MF_LOCKED && $stable(mf_sel_r)
        |-> MF_OUT == $past(locked_s))
        else $error("mf pin does not follow receiver lock");

endmodule // vfe_status_top

// >>> tb/vfe_src_model.sv
// upstream source model: frame timing, edh packets, header pulses
`timescale 1ns/1ns
module vfe_src_model (
    input  wire logic  clk,
    output logic       vblank,
    output logic       edh_pkt,
    output logic       trs,
    output logic       sdti,
    output logic [3:0] code,
    output logic       tdm,
    output logic       hds
);
    initial begin
        {vblank, edh_pkt, trs, sdti, code, tdm, hds} = '0;
    end
    // one frame: packet and headers inside blanking, then its falling edge
    task automatic frame(input logic e, input logic [3:0] k,
                         input logic [3:0] c);
        @(posedge clk);
        vblank <= 1'b1;
        @(posedge clk);
        edh_pkt <= e;
        {trs, sdti, tdm, hds} <= k;
        code <= c;
        @(posedge clk);
        {edh_pkt, trs, sdti, tdm, hds} <= '0;
        code <= ~c; // code is only meaningful beside its pulse
        @(posedge clk);
        vblank <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
endmodule // vfe_src_model

// >>> tb/vfe_status_top_test.sv
// self-checking bench for the status block
`timescale 1ns/1ns
module vfe_status_top_test;
    import vfe_pkg::*;
    logic        clk = 0, rst_n = 0, wr = 0, rd = 0, byp_n = 1, lk = 0;
    logic        mv = 0, mi = 0, vb, ep, trs, sd, tdm, hs, edh, mf;
    logic [3:0]  addr = '0, sc;
    logic [15:0] wd = '0, rdat, d, x;
    logic [1:0]  rate = '0;
    logic [10:0] ml = '0;
    logic [13:0] mw = '0, ma = '0;
    logic [3:0]  k;
    logic        e, c_on = 1;
    int          err_count = 0, cmp_count = 0;
    always #5 clk = ~clk;
    vfe_src_model u_src (.clk(clk), .vblank(vb), .edh_pkt(ep), .trs(trs),
        .sdti(sd), .code(sc), .tdm(tdm), .hds(hs));
    vfe_status_top u_dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr),
        .REG_WDATA(wd), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdat),
        .PROCESSING_BYPASS_N(byp_n), .LOCKED(lk), .RATE_INDICATION(rate),
        .MEAS_VALID(mv), .MEAS_LINES(ml), .MEAS_WORDS(mw),
        .MEAS_ACTIVE(ma), .MEAS_INTERLACED(mi), .VBLANK(vb), .EDH_PKT(ep),
        .Y_TRS(trs), .Y_SDTI(sd), .Y_SDTI_CODE(sc), .Y_TDM(tdm),
        .Y_HDSDTI(hs), .C_TRS(trs & c_on), .C_SDTI(sd), .C_SDTI_CODE(sc),
        .C_TDM(tdm), .C_HDSDTI(hs), .EDH_PRESENT_FLAG(edh), .MF_OUT(mf));
    // ====
    // bus and compare helpers
    task automatic check(input string n, input logic [15:0] s, x);
        cmp_count++;
        if (s !== x) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", n, x, s);
        end
    endtask
    task automatic rreg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdat; // read data stands only in this cycle
    endtask
    task automatic wreg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk);
        {wr, addr, wd} <= {1'b1, a, v};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic meas(input logic [1:0] r, input logic [10:0] l,
                        input logic [13:0] w, a);
        @(posedge clk);
        {mv, rate, ml, mw, ma, mi} <= {1'b1, r, l, w, a, 1'b1};
        @(posedge clk);
        mv <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // expected channel code: tdm beats sdti, no trs means undefined
    function automatic logic [3:0] fexp(logic [3:0] k, logic [3:0] c);
        return !k[3] ? FMT_UNDEF : k[1] ? FMT_TDM :
               k[2] & k[0] ? FMT_HDSDTI : k[2] ? c : FMT_SDI;
    endfunction
    task automatic tally_and_finish;
        $display("mismatches %0d of %0d compares", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ====
    // main sequence
    initial begin
        void'($urandom(32'h1555126B));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(ADDR_STD);
        check("std", d, 16'h0000);
        rreg(ADDR_FMT);
        check("fmt", d, 16'h00FF);
        meas(2'h1, 11'd625, 14'd1728, 14'd1440);
        rreg(ADDR_STD);
        check("code", {10'h0, d[5:0]}, 16'h0018);
        meas(2'h1, 11'd625, 14'd1728, 14'd1440);
        rreg(ADDR_STD);
        check("std625", d, 16'h0B58);
        for (int i = 0; i < 3; i++) begin
            meas(2'(i), 11'($urandom), 14'h2000 | 14'($urandom_range(0, 255)),
                 14'd1440);
            rreg(ADDR_STD);
            check("unk", {10'h0, d[5:0]}, 16'(i == 0 ? STD_UNK_HD :
                  i == 1 ? STD_UNK_SD : STD_UNK_3G));
        end
        @(posedge clk);
        byp_n <= 1'b0;
        rreg(ADDR_STD);
        rreg(ADDR_STD);
        // rate keeps tracking in bypass; only the four fields clear
        check("byp", d, {8'h00, RATE_3G, 6'h00});
        @(posedge clk);
        byp_n <= 1'b1;
        rate <= RATE_HD;
        lk <= 1'b1;
        // corner header mixes first, then random ones; chroma trs is
        // dropped in some frames so the two fields must part ways
        for (int i = 0; i < 16; i++) begin
            k = i < 5 ? 4'(20'h08CAD >> (i * 4)) : 4'($urandom);
            e = 1'($urandom);
            @(posedge clk);
            c_on <= i == 3 ? 1'b0 : 1'($urandom);
            repeat (2) u_src.frame(e, k, 4'($urandom_range(0, 5)));
            rreg(ADDR_FMT);
            x = {8'h00, fexp({k[3] & c_on, k[2:0]}, sc ^ 4'hF),
                 fexp(k, sc ^ 4'hF)};
            check("fmt", d, x);
            check("edh", 16'(edh), 16'(e));
            check("mf", 16'(mf), 16'(e));
        end
        @(posedge clk);
        rate <= 2'h1;
        repeat (2) u_src.frame(1'b1, 4'h8, 4'h0);
        rreg(ADDR_FMT);
        check("sdfmt", d, 16'h00F6);
        rreg(ADDR_EDH);
        check("edhreg", d, 16'h0001);
        @(posedge clk);
        lk <= 1'b0;
        repeat (2) u_src.frame(1'b1, 4'h8, 4'h0);
        rreg(ADDR_FMT);
        check("nolock", d, 16'h00FF);
        // a line length three words off misses at zero tolerance
        meas(2'h1, 11'd625, 14'd1731, 14'd1440);
        rreg(ADDR_STD);
        check("tol0", {10'h0, d[5:0]}, 16'(STD_UNK_SD));
        wreg(ADDR_CTRL, 16'h0017);
        rreg(ADDR_CTRL);
        check("ctrl", d, 16'h0014);
        meas(2'h1, 11'd625, 14'd1731, 14'd1440);
        rreg(ADDR_STD);
        check("tol4", {10'h0, d[5:0]}, 16'(STD_625I));
        @(posedge clk);
        lk <= 1'b1;
        wreg(ADDR_CTRL, 16'h0020);
        rreg(ADDR_CTRL);
        check("ctrl2", d, 16'h0020);
        check("mflock", 16'(mf), 16'h0001);
        tally_and_finish;
    end
endmodule // vfe_status_top_test
